// ==== hw/abm_regs.svh ====
// Constants for the access bank address mapper.
`ifndef ABM_REGS_SVH
`define ABM_REGS_SVH
`define ABM_ADDR_W 12
`define ABM_OFS_W 8
`define ABM_BANK_W 4
`define ABM_DATA_W 8
`define ABM_ACCESS_LOW_BYTES 8'h60
`define ABM_ACCESS_HIGH_BYTES 9'h0A0
`define ABM_LOW_BANK 4'h0
`define ABM_SFR_BANK 4'hF
`define ABM_BSR_RESET 8'h00
`define ABM_ZERO_BYTE 8'h00
`define ABM_ALL_BANKS 16'hFFFF
`endif

// ==== hw/abm_pkg.sv ====
// Types shared by the access bank address mapper files.
package abm_pkg;
	typedef enum logic [1:0] {
		ABM_SRC_NONE = 2'b00,
		ABM_SRC_BANKED = 2'b01,
		ABM_SRC_ACCESS = 2'b10,
		ABM_SRC_FULL = 2'b11
	} abm_src_t;
	typedef enum logic [1:0] {
		ABM_ST_IDLE = 2'b00,
		ABM_ST_ISSUE = 2'b01,
		ABM_ST_RETURN = 2'b10
	} abm_state_t;
endpackage

// ==== hw/abm_bank_select.sv ====
// Bank select register: four stored bits, upper nibble reads as zero.
`timescale 1ns/1ps
`include "abm_regs.svh"
module abm_bank_select
	import abm_pkg::*;
(
	// Clock and reset.
	input wire logic core_clk,
	input wire logic sys_rst,
	// Write port from the core.
	input wire logic wr_en,
	input wire logic [`ABM_DATA_W-1:0] wr_data,
	// Read view.
	output logic [`ABM_DATA_W-1:0] rd_data,
	output logic [`ABM_BANK_W-1:0] bank
);
	logic [`ABM_BANK_W-1:0] bank_reg;
	localparam logic [`ABM_DATA_W-1:0] RST_VAL = `ABM_BSR_RESET;

	// Only the low nibble is stored, so writes to the upper nibble vanish.
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			bank_reg <= RST_VAL[`ABM_BANK_W-1:0];
		end else if (wr_en) begin
			bank_reg <= wr_data[`ABM_BANK_W-1:0];
		end
	end

	// Read data is a flop so the top outputs stay registered.
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			rd_data <= RST_VAL;
		end else begin
			rd_data <= {{(`ABM_DATA_W-`ABM_BANK_W){1'b0}}, bank_reg};
		end
	end

	// The bank itself is used inside the mapper without delay.
	assign bank = bank_reg;
endmodule // abm_bank_select

// ==== hw/abm_address_mapper.sv ====
// Direct-address former with access bank, bank select and full-address moves.
`timescale 1ns/1ps
`include "abm_regs.svh"
module abm_address_mapper
	import abm_pkg::*;
#(
	parameter logic [15:0] BANK_IMPL_MASK = `ABM_ALL_BANKS
)
(
	// Clock and reset.
	input wire logic core_clk,
	input wire logic sys_rst,
	// Direct-addressed request from the instruction decoder.
	input wire logic dir_valid,
	input wire logic [`ABM_OFS_W-1:0] dir_offset,
	input wire logic dir_access_n,
	input wire logic dir_rd,
	input wire logic dir_wr,
	input wire logic [`ABM_DATA_W-1:0] dir_wr_data,
	// Full-address move request.
	input wire logic full_valid,
	input wire logic [`ABM_ADDR_W-1:0] full_addr,
	input wire logic full_rd,
	input wire logic full_wr,
	input wire logic [`ABM_DATA_W-1:0] full_wr_data,
	// Bank select register access.
	input wire logic bsel_wr_en,
	input wire logic [`ABM_DATA_W-1:0] bsel_wr_data,
	output logic [`ABM_DATA_W-1:0] bsel_rd_data,
	// Data memory side.
	output logic [`ABM_ADDR_W-1:0] mem_addr_reg,
	output logic mem_rd_en_reg,
	output logic mem_wr_en_reg,
	output logic [`ABM_DATA_W-1:0] mem_wr_data_reg,
	input wire logic [`ABM_DATA_W-1:0] mem_rd_data,
	// Answer to the core.
	output logic [`ABM_DATA_W-1:0] core_rd_data_reg,
	output logic core_rd_valid_reg,
	output logic flag_update_reg,
	output logic bank_missing_reg,
	output abm_src_t addr_src_reg
);
	logic [`ABM_BANK_W-1:0] bank_sel;
	logic [`ABM_ADDR_W-1:0] addr_next;
	abm_src_t src_next;
	logic rd_next;
	logic wr_next;
	logic [`ABM_DATA_W-1:0] wdata_next;
	logic impl_next;
	logic req_any;
	logic rd_pending_reg;
	logic missing_pending_reg;
	abm_state_t state_reg;
	abm_state_t state_next;

	// Bank select storage lives in its own small module.
	abm_bank_select u_bank_select (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.wr_en(bsel_wr_en),
		.wr_data(bsel_wr_data),
		.rd_data(bsel_rd_data),
		.bank(bank_sel)
	);

	// Access window split: low part of bank 0 then SFR part of bank 15.
	// Because the offset itself is kept, the two parts meet with no gap or overlap.
	function automatic logic [`ABM_ADDR_W-1:0] access_map(input logic [`ABM_OFS_W-1:0] ofs);
		logic [`ABM_BANK_W-1:0] bank;
		bank = (ofs < `ABM_ACCESS_LOW_BYTES) ? `ABM_LOW_BANK : `ABM_SFR_BANK;
		return {bank, ofs};
	endfunction

	// A bank is present when its bit in the implemented-bank mask is set.
	function automatic logic bank_present(input logic [`ABM_ADDR_W-1:0] addr);
		return BANK_IMPL_MASK[addr[`ABM_ADDR_W-1 -: `ABM_BANK_W]];
	endfunction

	// Any request at all, of either kind.
	assign req_any = dir_valid | full_valid;

	// Address selection; a full-address move takes precedence since it
	// carries its own address and never consults the bank select register.
	always_comb begin
		addr_next = '0;
		src_next = ABM_SRC_NONE;
		rd_next = 1'b0;
		wr_next = 1'b0;
		wdata_next = `ABM_ZERO_BYTE;
		if (full_valid) begin
			addr_next = full_addr;
			src_next = ABM_SRC_FULL;
			rd_next = full_rd;
			wr_next = full_wr;
			wdata_next = full_wr_data;
		end else if (dir_valid) begin
			if (!dir_access_n) begin
				addr_next = access_map(dir_offset);
				src_next = ABM_SRC_ACCESS;
			end else begin
				addr_next = {bank_sel, dir_offset};
				src_next = ABM_SRC_BANKED;
			end
			rd_next = dir_rd;
			wr_next = dir_wr;
			wdata_next = dir_wr_data;
		end
		impl_next = bank_present(addr_next);
	end

	// Small sequencer: issue the access, then return read data a cycle later.
	// It only tracks the bus phase; every output below is timed by its own flops.
	always_comb begin
		case (state_reg)
			ABM_ST_IDLE: state_next = req_any ? ABM_ST_ISSUE : ABM_ST_IDLE;
			ABM_ST_ISSUE: state_next = rd_pending_reg ? ABM_ST_RETURN :
				(req_any ? ABM_ST_ISSUE : ABM_ST_IDLE);
			ABM_ST_RETURN: state_next = req_any ? ABM_ST_ISSUE : ABM_ST_IDLE;
			default: state_next = ABM_ST_IDLE;
		endcase
	end

	// Sequencer state register.
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			state_reg <= ABM_ST_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	// Address, data and source follow the request every cycle; with no
	// request they fall back to zero, which keeps the memory bus quiet.
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			mem_addr_reg <= '0;
			mem_wr_data_reg <= `ABM_ZERO_BYTE;
			addr_src_reg <= ABM_SRC_NONE;
		end else begin
			mem_addr_reg <= addr_next;
			mem_wr_data_reg <= wdata_next;
			addr_src_reg <= src_next;
		end
	end

	// Strobes are gated by the bank mask, so a missing bank never sees a
	// write; the address still shows where the instruction pointed.
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			mem_rd_en_reg <= 1'b0;
			mem_wr_en_reg <= 1'b0;
		end else begin
			mem_rd_en_reg <= rd_next & impl_next;
			mem_wr_en_reg <= wr_next & impl_next;
		end
	end

	// Status flags follow a direct instruction even when its bank is missing.
	// Full-address moves leave the flags alone, so they raise no pulse.
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			flag_update_reg <= 1'b0;
		end else begin
			flag_update_reg <= dir_valid & ~full_valid;
		end
	end

	// One pulse for each request that points into an unimplemented bank.
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			bank_missing_reg <= 1'b0;
		end else begin
			bank_missing_reg <= req_any & ~impl_next;
		end
	end

	// A read in flight; the memory answers while its strobe stands.
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			rd_pending_reg <= 1'b0;
		end else begin
			rd_pending_reg <= req_any & rd_next;
		end
	end

	// Whether the read in flight targets a missing bank, since its strobe was
	// withheld and the memory data bus then carries nothing worth keeping.
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			missing_pending_reg <= 1'b0;
		end else begin
			missing_pending_reg <= ~impl_next;
		end
	end

	// Read result marker, one cycle after the memory strobe.
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			core_rd_valid_reg <= 1'b0;
		end else begin
			core_rd_valid_reg <= rd_pending_reg;
		end
	end

	// Read data is captured while the memory strobe stands and then holds
	// until the next read; a missing bank reads as zero.
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			core_rd_data_reg <= `ABM_ZERO_BYTE;
		end else if (rd_pending_reg) begin
			core_rd_data_reg <= missing_pending_reg ? `ABM_ZERO_BYTE : mem_rd_data;
		end
	end
endmodule // abm_address_mapper

// ==== tb/abm_address_mapper_assertions.sv ====
// Port checker for the access bank address mapper.
`timescale 1ns/1ps
module abm_checker
	import abm_pkg::*;
(
	// Clock and reset.
	input wire logic core_clk,
	input wire logic sys_rst,
	// Requests from the decoder.
	input wire logic dir_valid,
	input wire logic [7:0] dir_offset,
	input wire logic dir_access_n,
	input wire logic dir_rd,
	input wire logic full_valid,
	input wire logic [11:0] full_addr,
	input wire logic full_rd,
	// Bank select view.
	input wire logic [7:0] bsel_rd_data,
	// Memory side.
	input wire logic [11:0] mem_addr_reg,
	input wire logic mem_rd_en_reg,
	input wire logic mem_wr_en_reg,
	input wire logic [7:0] mem_rd_data,
	// Answer to the core.
	input wire logic [7:0] core_rd_data_reg,
	input wire logic core_rd_valid_reg,
	input wire logic flag_update_reg,
	input wire logic bank_missing_reg,
	input wire abm_src_t addr_src_reg
);
	// A full move beats a direct request in the same cycle.
	wire dreq = dir_valid && !full_valid;
	// The read flag of whichever request wins the cycle.
	wire rd_req = full_valid ? full_rd : (dir_valid && dir_rd);
	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	// Address and flag answers follow the request by one cycle; read answers follow its strobe by one more.
	acc_map_a: assert property (dreq && !dir_access_n |=>
		mem_addr_reg == {($past(dir_offset) < 8'h60) ? 4'h0 : 4'hF, $past(dir_offset)})
		else $error("access map");
	bank_map_a: assert property (dreq && dir_access_n |=> addr_src_reg == ABM_SRC_BANKED
		&& mem_addr_reg[7:0] == $past(dir_offset)) else $error("banked map");
	full_map_a: assert property (full_valid |=> mem_addr_reg == $past(full_addr))
		else $error("full map");
	bsel_top_a: assert property (bsel_rd_data[7:4] == 4'h0) else $error("bank top");
	miss_drop_a: assert property (bank_missing_reg |-> !mem_wr_en_reg)
		else $error("missing write");
	flag_upd_a: assert property (dreq |=> flag_update_reg) else $error("no flag");
	miss_zero_a: assert property (bank_missing_reg && $past(rd_req) |=>
		core_rd_valid_reg && core_rd_data_reg == 8'h00) else $error("missing read");
	rd_data_a: assert property (mem_rd_en_reg |=> core_rd_valid_reg
		&& core_rd_data_reg == $past(mem_rd_data)) else $error("read data");
	cover property (dreq && !dir_access_n && dir_offset >= 8'h60);
	cover property (full_valid && dir_valid);
	cover property (bank_missing_reg);
endmodule // abm_checker
bind abm_address_mapper abm_checker abm_checker_inst (
	.core_clk(core_clk),
	.sys_rst(sys_rst),
	.dir_valid(dir_valid),
	.dir_offset(dir_offset),
	.dir_access_n(dir_access_n),
	.dir_rd(dir_rd),
	.full_valid(full_valid),
	.full_addr(full_addr),
	.full_rd(full_rd),
	.bsel_rd_data(bsel_rd_data),
	.mem_addr_reg(mem_addr_reg),
	.mem_rd_en_reg(mem_rd_en_reg),
	.mem_wr_en_reg(mem_wr_en_reg),
	.mem_rd_data(mem_rd_data),
	.core_rd_data_reg(core_rd_data_reg),
	.core_rd_valid_reg(core_rd_valid_reg),
	.flag_update_reg(flag_update_reg),
	.bank_missing_reg(bank_missing_reg),
	.addr_src_reg(addr_src_reg)
);

// ==== tb/abm_mem_model.sv ====
// Data memory model on the far side of the mapper.
`timescale 1ns/1ps
module abm_mem_model (
	// Clock.
	input wire logic core_clk,
	// Memory port of the mapper.
	input wire logic mem_rd_en_reg,
	input wire logic mem_wr_en_reg,
	input wire logic [11:0] mem_addr_reg,
	input wire logic [7:0] mem_wr_data_reg,
	// Data back to the mapper.
	output logic [7:0] mem_rd_data
);
	logic [7:0] ram [4096];
	// Writes land at the edge that carries the strobe.
	always @(posedge core_clk) if (mem_wr_en_reg) ram[mem_addr_reg] <= mem_wr_data_reg;
	// Off the strobe the bus shows inverted junk, so a late capture cannot pass.
	assign mem_rd_data = mem_rd_en_reg ? ram[mem_addr_reg] : ~ram[mem_addr_reg];
endmodule // abm_mem_model

// ==== tb/abm_address_mapper_test.sv ====
// Self-checking bench for the access bank address mapper.
`timescale 1ns/1ps
module abm_address_mapper_test;
	logic core_clk = 1'h0;
	logic sys_rst, dir_valid, dir_access_n, dir_rd, dir_wr, full_valid, full_rd, full_wr;
	logic bsel_wr_en, mem_rd_en_reg, mem_wr_en_reg, core_rd_valid_reg, flag_update_reg;
	logic bank_missing_reg;
	logic [7:0] dir_offset, dir_wr_data, full_wr_data, bsel_wr_data, bsel_rd_data;
	logic [7:0] mem_wr_data_reg, mem_rd_data, core_rd_data_reg;
	logic [11:0] full_addr, mem_addr_reg;
	abm_pkg::abm_src_t addr_src_reg;
	int err_total = 0, checks_done = 0;
	// Mapper with bank 5 left out, beside its data memory.
	abm_address_mapper #(.BANK_IMPL_MASK(16'hFFDF)) abm_address_mapper_inst (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.dir_valid(dir_valid),
		.dir_offset(dir_offset),
		.dir_access_n(dir_access_n),
		.dir_rd(dir_rd),
		.dir_wr(dir_wr),
		.dir_wr_data(dir_wr_data),
		.full_valid(full_valid),
		.full_addr(full_addr),
		.full_rd(full_rd),
		.full_wr(full_wr),
		.full_wr_data(full_wr_data),
		.bsel_wr_en(bsel_wr_en),
		.bsel_wr_data(bsel_wr_data),
		.bsel_rd_data(bsel_rd_data),
		.mem_addr_reg(mem_addr_reg),
		.mem_rd_en_reg(mem_rd_en_reg),
		.mem_wr_en_reg(mem_wr_en_reg),
		.mem_wr_data_reg(mem_wr_data_reg),
		.mem_rd_data(mem_rd_data),
		.core_rd_data_reg(core_rd_data_reg),
		.core_rd_valid_reg(core_rd_valid_reg),
		.flag_update_reg(flag_update_reg),
		.bank_missing_reg(bank_missing_reg),
		.addr_src_reg(addr_src_reg)
	);
	abm_mem_model abm_mem_model_inst (
		.core_clk(core_clk),
		.mem_rd_en_reg(mem_rd_en_reg),
		.mem_wr_en_reg(mem_wr_en_reg),
		.mem_addr_reg(mem_addr_reg),
		.mem_wr_data_reg(mem_wr_data_reg),
		.mem_rd_data(mem_rd_data)
	);
	// Free-running core clock.
	initial forever #2.5 core_clk = ~core_clk;
	// Count one comparison and report a mismatch.
	task automatic chk(string n, logic [11:0] e, g);
		checks_done++;
		err_total += int'(g !== e);
		if (g !== e) $display("unexpected %s expected %h seen %h", n, e, g);
	endtask
	// One request; a read also checks the byte that comes back.
	task automatic op(logic f, a, w, logic [11:0] ad, ea, logic [7:0] d);
		@(posedge core_clk);
		{full_valid, dir_valid, dir_access_n, dir_offset, full_addr} <= {f, 1'h1, a, ad[7:0], ad};
		{dir_wr, full_wr, dir_rd, full_rd, dir_wr_data, full_wr_data} <= {w, w, !w, !w, d, d};
		@(posedge core_clk);
		{full_valid, dir_valid} <= 2'h0;
		#1 chk("mem_addr_reg", ea, mem_addr_reg);
		chk("addr_src_reg", {10'h000, (f ? abm_pkg::ABM_SRC_FULL : (a ? abm_pkg::ABM_SRC_BANKED :
			abm_pkg::ABM_SRC_ACCESS))}, {10'h000, addr_src_reg});
		if (!w) begin
			@(posedge core_clk) #1 chk("core_rd_data_reg", {4'h0, d}, {4'h0, core_rd_data_reg});
			chk("core_rd_valid_reg", 12'h001, {11'h000, core_rd_valid_reg});
		end
	endtask
	// Load the bank select register and read it back after its update.
	task automatic bank(logic [7:0] v);
		@(posedge core_clk);
		{bsel_wr_en, bsel_wr_data} <= {1'h1, v};
		@(posedge core_clk);
		bsel_wr_en <= 1'h0;
		@(posedge core_clk) #1 chk("bsel_rd_data", {8'h00, v[3:0]}, {4'h0, bsel_rd_data});
	endtask
	// Access bank edges; full moves override both the bank and a direct request.
	task automatic s_map;
		op(0, 0, 1, 12'h05F, 12'h05F, 8'hA5);
		op(0, 0, 1, 12'h060, 12'hF60, 8'h3C);
		op(0, 0, 1, 12'h0FF, 12'hFFF, 8'h77);
		op(1, 0, 0, 12'h05F, 12'h05F, 8'hA5);
		op(1, 1, 1, 12'hABC, 12'hABC, 8'h42);
	endtask
	// Banked mode, register reach from another bank, and an absent bank.
	task automatic s_bank;
		bank(8'hAA);
		op(0, 1, 0, 12'h0BC, 12'hABC, 8'h42);
		op(0, 0, 0, 12'h060, 12'hF60, 8'h3C);
		bank(8'h05);
		op(0, 1, 1, 12'h040, 12'h540, 8'h11);
		chk("miss", 12'h003, {9'h000, mem_wr_en_reg, flag_update_reg, bank_missing_reg});
		op(0, 1, 0, 12'h040, 12'h540, 8'h00);
	endtask
	// Print the counts and the verdict, then stop.
	task automatic wrap_up;
		$display("checks %0d errors %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	// Reset for 20 cycles, then run the scenarios.
	initial begin
		{sys_rst, dir_valid, full_valid, bsel_wr_en} = 4'h8;
		{dir_access_n, dir_rd, dir_wr, full_rd, full_wr, dir_offset, full_addr} = 25'h0;
		{dir_wr_data, full_wr_data, bsel_wr_data} = 24'h0;
		repeat (20) @(posedge core_clk);
		sys_rst <= 1'h0;
		s_map();
		s_bank();
		wrap_up();
	end
	// The run takes about fifty cycles; a hang is cut off long after.
	initial begin
		#20000;
		err_total++;
		wrap_up();
	end
endmodule // abm_address_mapper_test
